// file: acsc_pkg.sv
/*
 * Constants for the converter scan control block: register indexes,
 * control bit positions, reset values and scan encodings.
 * Assumes APB with 32-bit data; byte address is four times the index.
 */
package acsc_pkg;

    // Register indexes (byte address = index * 4)
    localparam logic [7:0] IDX_PIN_PORT  = 8'hc7;
    localparam logic [7:0] IDX_CONTROL   = 8'hd7;
    localparam logic [7:0] IDX_SCAN_SEL  = 8'he7;
    localparam logic [7:0] IDX_HIGH_BITS = 8'hf7;
    // Low-byte result registers sit at 86, 96 ... f6
    localparam logic [3:0] LOW_IDX_NIBBLE = 4'h6;
    localparam int         LOW_IDX_TOP    = 7;
    localparam int         LOW_CHAN_MSB   = 6;
    localparam int         LOW_CHAN_LSB   = 4;

    // Control register bit positions
    localparam int BIT_PRESCALE_HI = 7;
    localparam int BIT_PRESCALE_LO = 6;
    localparam int BIT_RESERVED    = 5;
    localparam int BIT_SCAN_DONE   = 4;
    localparam int BIT_START       = 3;
    localparam int BIT_CONTINUOUS  = 2;
    localparam int BIT_RISE_EN     = 1;
    localparam int BIT_FALL_EN     = 0;

    // Reset values
    localparam logic [7:0] CONTROL_RESET  = 8'h00;
    localparam logic [7:0] SCAN_SEL_RESET = 8'h00;
    localparam logic [1:0] PRESCALE_RESET = 2'h0;

    // Scan limits
    localparam logic [2:0] FIRST_CHANNEL = 3'h0;
    localparam logic [2:0] LAST_CHANNEL  = 3'h7;

    // Prescaler: divisor m = 2 * (code + 1), counted from zero
    localparam logic [2:0] PRESCALE_ZERO = 3'h0;

    // Unused upper bits of the high-bits register read as zero
    localparam logic [5:0] HIGH_PAD = 6'h00;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SEEK,
        ST_CONVERT,
        ST_LOOP_END
    } acsc_state_t;

endpackage

// file: acsc_top.sv
/*
 * Scan control for an eight-channel 10-bit converter: scan-select mask,
 * prescaler, start and status handling, one-time and continuous
 * autoscan, completion flag, external edge start with capture pulse,
 * per-channel results and the shared high-bits register.
 * Assumes an APB master on one 10 MHz clock, an analog core that takes
 * a start pulse with a channel number, runs on the prescaler enable and
 * answers with a done pulse and a 10-bit result. All inputs are
 * synchronous to i_clock.
 */
//
// Behaviour
// - High-bits register upper six bits read zero
// - High-bits bits 1:0 show result bits 9:8
// - Empty scan mask never starts a conversion
// - Mask change applies from the next loop
// - Unselected channels are skipped in a loop
// - Control bits 7:6 pick divisor 2/4/6/8
// - Completion flag set when loop finishes
// - Only software clears flag; writing one ignored
// - Interrupt request while flag set and enabled
// - Start bit set by software or edge starts
// - Continuous mode with a non-empty mask keeps start bit, repeats loops
// - One-time mode clears start bit at end
// - Start requests ignored while start bit set
// - Software clearing start bit aborts conversion
// - Control bit 2 picks continuous or single pass
// - Enabled rising edge starts and captures
// - Enabled falling edge starts and captures
// - Pin port reads live pin levels, no reset
// - Pin port reads have no side effect
// - Low-byte read latches that channel high bits
// - Each channel keeps its own low byte
// - Reset clears control, mask; results untouched
// - Power save aborts, clears start, stops clock
`timescale 1ns/100ps

module acsc_top (
    input  wire logic        i_clock,
    input  wire logic        i_reset_n,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Pins and system
    input  wire logic [7:0]  i_analog_pins,
    input  wire logic        i_external_start_input,
    input  wire logic        i_power_save,
    input  wire logic        i_int_enable,
    output logic             o_irq,
    output logic             o_capture,
    // Analog core
    output logic             o_conv_start,
    output logic [2:0]       o_conv_channel,
    output logic             o_conv_clk_en,
    output logic             o_conv_abort,
    input  wire logic        i_conv_done,
    input  wire logic [9:0]  i_conv_result
);

    acsc_pkg::acsc_state_t state_ff;

    logic [1:0] prescale_ff;
    logic       scan_done_ff;
    logic       start_ff;
    logic       continuous_ff;
    logic       rise_en_ff;
    logic       fall_en_ff;
    logic [7:0] scan_select_ff;
    logic [7:0] loop_mask_ff;
    logic [2:0] chan_ff;
    logic [2:0] pre_cnt_ff;
    logic [2:0] pre_last;
    logic       ext_prev_ff;
    logic [1:0] high_bits_ff;
    logic [7:0] result_low_ff [8];
    logic [1:0] result_high_ff [8];

    logic [7:0] idx;
    logic       idx_low;
    logic [2:0] idx_chan;
    logic       hit;
    logic       access;
    logic       wr_ctrl;
    logic       wr_scan;
    logic       rd_low;
    logic       rd_setup;
    logic       rise_ev;
    logic       fall_ev;
    logic       sw_start;
    logic       start_req;
    logic       abort;
    logic       loop_end;
    logic       keep_running;
    logic       running;

    // Address decode; bits above the index must be zero
    assign idx      = i_paddr[9:2];
    assign idx_low  = idx[acsc_pkg::LOW_IDX_TOP] &&
                      (idx[3:0] == acsc_pkg::LOW_IDX_NIBBLE);
    assign idx_chan = idx[acsc_pkg::LOW_CHAN_MSB:acsc_pkg::LOW_CHAN_LSB];
    assign hit      = (i_paddr[11:10] == 2'h0) &&
                      (idx_low || idx == acsc_pkg::IDX_PIN_PORT ||
                       idx == acsc_pkg::IDX_CONTROL ||
                       idx == acsc_pkg::IDX_SCAN_SEL ||
                       idx == acsc_pkg::IDX_HIGH_BITS);
    assign access   = i_psel && i_penable;
    assign wr_ctrl  = access && i_pwrite && hit &&
                      idx == acsc_pkg::IDX_CONTROL;
    assign wr_scan  = access && i_pwrite && hit &&
                      idx == acsc_pkg::IDX_SCAN_SEL;
    // Setup-phase read: low byte and high-bits latch share one edge,
    // so a result landing mid-transfer cannot split the pair
    assign rd_setup = i_psel && !i_penable && !i_pwrite;
    assign rd_low   = rd_setup && hit && idx_low;

    // Zero-wait slave; unmapped addresses answer with an error
    // Read-only registers drop writes quietly, with no error
    assign o_pready  = 1'b1;
    assign o_pslverr = access && !hit;

    // Read data captured in the setup cycle, held through access
    // and on until the next read setup
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            o_prdata <= 32'h0000_0000;
            if (hit) begin
                if (idx_low) begin
                    o_prdata[7:0] <= result_low_ff[idx_chan];
                end else if (idx == acsc_pkg::IDX_PIN_PORT) begin
                    o_prdata[7:0] <= i_analog_pins;
                end else if (idx == acsc_pkg::IDX_CONTROL) begin
                    o_prdata[7:0] <= {prescale_ff, 1'b0, scan_done_ff,
                                      start_ff, continuous_ff,
                                      rise_en_ff, fall_en_ff};
                end else if (idx == acsc_pkg::IDX_SCAN_SEL) begin
                    o_prdata[7:0] <= scan_select_ff;
                end else begin
                    o_prdata[7:0] <= {acsc_pkg::HIGH_PAD, high_bits_ff};
                end
            end
        end
    end

    // External start edge detector; input already synchronous
    // Both enables are clear after reset, so no false edge can start
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            ext_prev_ff <= 1'b0;
        end else begin
            ext_prev_ff <= i_external_start_input;
        end
    end

    // rising edge gated by its enable
    assign rise_ev = rise_en_ff && i_external_start_input && !ext_prev_ff;
    // falling edge gated by its enable
    assign fall_ev = fall_en_ff && !i_external_start_input && ext_prev_ff;

    // Capture pulse for every enabled edge, busy or not
    // The consumer of the capture decides what a busy edge means
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_capture <= 1'b0;
        end else begin
            o_capture <= rise_ev || fall_ev;
        end
    end

    // Software start: a control write with the start bit set
    assign sw_start = wr_ctrl && i_pwdata[acsc_pkg::BIT_START];
    // Live mask checked, so an empty mask refuses every source
    // no start on empty mask or while busy
    assign start_req = (sw_start || rise_ev || fall_ev) && !start_ff &&
                       (scan_select_ff != 8'h00) && !i_power_save;
    // Abort needs the start bit: a clear write while idle does nothing
    // software clear or power save aborts
    assign abort = start_ff &&
                   (i_power_save ||
                    (wr_ctrl && !i_pwdata[acsc_pkg::BIT_START]));
    assign loop_end     = (state_ff == acsc_pkg::ST_LOOP_END);
    assign keep_running = continuous_ff && (scan_select_ff != 8'h00);
    assign running      = (state_ff != acsc_pkg::ST_IDLE);

    // Control configuration bits
    // Start and flag bits have their own processes below
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            prescale_ff   <= acsc_pkg::PRESCALE_RESET;
            continuous_ff <= acsc_pkg::CONTROL_RESET[acsc_pkg::BIT_CONTINUOUS];
            rise_en_ff    <= acsc_pkg::CONTROL_RESET[acsc_pkg::BIT_RISE_EN];
            fall_en_ff    <= acsc_pkg::CONTROL_RESET[acsc_pkg::BIT_FALL_EN];
        end else if (wr_ctrl) begin
            prescale_ff   <= i_pwdata[acsc_pkg::BIT_PRESCALE_HI:
                                      acsc_pkg::BIT_PRESCALE_LO];
            continuous_ff <= i_pwdata[acsc_pkg::BIT_CONTINUOUS];
            rise_en_ff    <= i_pwdata[acsc_pkg::BIT_RISE_EN];
            fall_en_ff    <= i_pwdata[acsc_pkg::BIT_FALL_EN];
        end
    end

    // Start and status bit
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            start_ff <= acsc_pkg::CONTROL_RESET[acsc_pkg::BIT_START];
        end else if (start_req) begin
            start_ff <= 1'b1;
        end else if (abort) begin
            start_ff <= 1'b0;
        end else if (loop_end && !keep_running) begin
            start_ff <= 1'b0;
        end
    end

    // Completion flag: hardware set beats software clear
    // A clear landing in the loop-end cycle loses, so no loop is missed
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            scan_done_ff <= acsc_pkg::CONTROL_RESET[acsc_pkg::BIT_SCAN_DONE];
        end else if (loop_end) begin
            // set at end of every loop
            scan_done_ff <= 1'b1;
        end else if (wr_ctrl && !i_pwdata[acsc_pkg::BIT_SCAN_DONE]) begin
            scan_done_ff <= 1'b0;
        end
    end

    assign o_irq = scan_done_ff && i_int_enable;

    // Scan-select mask, copied into the loop mask per loop
    // Software may rewrite it mid-loop; the sequencer keeps its copy
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            scan_select_ff <= acsc_pkg::SCAN_SEL_RESET;
        end else if (wr_scan) begin
            scan_select_ff <= i_pwdata[7:0];
        end
    end

    // Autoscan sequencer
    // One cycle per skipped channel; abort returns to idle from anywhere
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            state_ff     <= acsc_pkg::ST_IDLE;
            chan_ff      <= acsc_pkg::FIRST_CHANNEL;
            loop_mask_ff <= acsc_pkg::SCAN_SEL_RESET;
            o_conv_start <= 1'b0;
            o_conv_abort <= 1'b0;
        end else begin
            o_conv_start <= 1'b0;
            o_conv_abort <= 1'b0;
            if (abort) begin
                // Abort wins over a done in the same cycle
                state_ff     <= acsc_pkg::ST_IDLE;
                o_conv_abort <= 1'b1;
            end else begin
                case (state_ff)
                    acsc_pkg::ST_IDLE: begin
                        if (start_req) begin
                            // loop uses a snapshot of the mask
                            loop_mask_ff <= scan_select_ff;
                            chan_ff      <= acsc_pkg::FIRST_CHANNEL;
                            state_ff     <= acsc_pkg::ST_SEEK;
                        end
                    end
                    acsc_pkg::ST_SEEK: begin
                        if (loop_mask_ff[chan_ff]) begin
                            o_conv_start <= 1'b1;
                            state_ff     <= acsc_pkg::ST_CONVERT;
                        end else if (chan_ff == acsc_pkg::LAST_CHANNEL) begin
                            state_ff <= acsc_pkg::ST_LOOP_END;
                        end else begin
                            chan_ff <= chan_ff + 3'h1;
                        end
                    end
                    acsc_pkg::ST_CONVERT: begin
                        if (i_conv_done) begin
                            if (chan_ff == acsc_pkg::LAST_CHANNEL) begin
                                state_ff <= acsc_pkg::ST_LOOP_END;
                            end else begin
                                chan_ff  <= chan_ff + 3'h1;
                                state_ff <= acsc_pkg::ST_SEEK;
                            end
                        end
                    end
                    acsc_pkg::ST_LOOP_END: begin
                        if (keep_running) begin
                            // new mask taken at loop start
                            loop_mask_ff <= scan_select_ff;
                            chan_ff      <= acsc_pkg::FIRST_CHANNEL;
                            state_ff     <= acsc_pkg::ST_SEEK;
                        end else begin
                            state_ff <= acsc_pkg::ST_IDLE;
                        end
                    end
                    default: begin
                        state_ff <= acsc_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Channel held from seek through done, straight from its flop
    assign o_conv_channel = chan_ff;

    // Divider end count: codes 0 to 3 give 1, 3, 5, 7, so m is 2 to 8
    assign pre_last = {prescale_ff, 1'b1};

    // Prescaler; halted while idle so power save stops the clock
    // Starts from zero on each start from idle, so the first period is full
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            pre_cnt_ff    <= acsc_pkg::PRESCALE_ZERO;
            o_conv_clk_en <= 1'b0;
        end else if (!running || abort) begin
            pre_cnt_ff    <= acsc_pkg::PRESCALE_ZERO;
            o_conv_clk_en <= 1'b0;
        end else if (pre_cnt_ff >= pre_last) begin
            pre_cnt_ff    <= acsc_pkg::PRESCALE_ZERO;
            o_conv_clk_en <= 1'b1;
        end else begin
            pre_cnt_ff    <= pre_cnt_ff + 3'h1;
            o_conv_clk_en <= 1'b0;
        end
    end

    // Result storage; no reset so results survive chip reset
    always_ff @(posedge i_clock) begin
        if (state_ff == acsc_pkg::ST_CONVERT && i_conv_done && !abort) begin
            result_low_ff[chan_ff]  <= i_conv_result[7:0];
            result_high_ff[chan_ff] <= i_conv_result[9:8];
        end
    end

    // Shared high bits, latched by a low-byte read at its setup edge,
    // the same edge that samples the low byte; no reset, like results
    always_ff @(posedge i_clock) begin
        if (rd_low) begin
            high_bits_ff <= result_high_ff[idx_chan];
        end
    end

endmodule

// file: acsc_top_asserts.sv
/*
 * Port checker for the converter scan control block: register reads,
 * interrupt level, capture and converter pulses, aborts.
 * Assumes one clock domain and is bound to every acsc_top instance.
 */
`timescale 1ns/100ps
module acsc_top_asserts (
    input wire logic        i_clock,
    input wire logic        i_reset_n,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic [7:0]  i_analog_pins,
    input wire logic        i_external_start_input,
    input wire logic        i_power_save,
    input wire logic        i_int_enable,
    input wire logic        o_irq,
    input wire logic        o_capture,
    input wire logic        o_conv_start,
    input wire logic [2:0]  o_conv_channel,
    input wire logic        o_conv_clk_en,
    input wire logic        o_conv_abort,
    input wire logic        i_conv_done,
    input wire logic [9:0]  i_conv_result
);
    // Access phases by register
    logic ctrl_wr;
    logic hi_rd;
    logic pin_rd;
    assign ctrl_wr = i_psel && i_penable && i_pwrite &&
                     i_paddr[9:2] == acsc_pkg::IDX_CONTROL;
    assign hi_rd = i_psel && i_penable && !i_pwrite &&
                   i_paddr[9:2] == acsc_pkg::IDX_HIGH_BITS;
    assign pin_rd = i_psel && i_penable && !i_pwrite &&
                    i_paddr[9:2] == acsc_pkg::IDX_PIN_PORT;

    default clocking dcb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);

    a_high_pad_zero: assert property (hi_rd |-> o_prdata[31:2] == 30'h0)
        else $error("high bits pad not zero");
    // Data loaded at the setup edge, one cycle back
    a_pin_port_live: assert property (
        pin_rd |-> o_prdata == {24'h0, $past(i_analog_pins)})
        else $error("pin port read wrong");
    a_irq_needs_en: assert property (o_irq |-> i_int_enable)
        else $error("irq without enable");
    a_flag_sticky: assert property (
        o_irq && !ctrl_wr |=> o_irq || !i_int_enable)
        else $error("done flag cleared by hardware");
    a_capture_edge: assert property (
        o_capture |-> $past(i_external_start_input) !=
                      $past(i_external_start_input, 2))
        else $error("capture without edge");
    a_start_pulse: assert property (o_conv_start |=> !o_conv_start)
        else $error("start pulse too long");
    a_abort_cause: assert property (
        o_conv_abort |->
            $past(ctrl_wr && !i_pwdata[acsc_pkg::BIT_START]) ||
            $past(ctrl_wr && !i_pwdata[acsc_pkg::BIT_START], 2) ||
            $past(i_power_save) || $past(i_power_save, 2))
        else $error("abort without cause");
    a_save_blocks: assert property (
        $past(i_power_save) && $past(i_power_save, 2) |->
        !o_conv_start && !o_conv_clk_en)
        else $error("activity in power save");
    a_clk_en_pulse: assert property (o_conv_clk_en |=> !o_conv_clk_en)
        else $error("prescaler enable too long");

    // Main scenarios reached
    c_capture: cover property (o_capture);
    c_irq: cover property (o_irq);
    c_abort: cover property (o_conv_abort);
endmodule

bind acsc_top acsc_top_asserts acsc_top_asserts_i (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_analog_pins(i_analog_pins),
    .i_external_start_input(i_external_start_input),
    .i_power_save(i_power_save), .i_int_enable(i_int_enable),
    .o_irq(o_irq), .o_capture(o_capture), .o_conv_start(o_conv_start),
    .o_conv_channel(o_conv_channel), .o_conv_clk_en(o_conv_clk_en),
    .o_conv_abort(o_conv_abort), .i_conv_done(i_conv_done),
    .i_conv_result(i_conv_result));

// file: tb_top.sv
/*
 * Self-checking bench for acsc_top: APB master tasks, a behavioural
 * analog core answering start pulses, and one task per scenario.
 * Assumes zero or more APB wait states and a 10 MHz clock.
 */
`timescale 1ns/100ps
module tb_top;
    localparam logic [7:0] CTRL = acsc_pkg::IDX_CONTROL;
    localparam logic [7:0] SCAN = acsc_pkg::IDX_SCAN_SEL;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [7:0]  pins = 8'h3c;
    logic        ext = 1'b0;
    logic        psave = 1'b0;
    logic        int_en = 1'b1;
    logic        conv_done = 1'b0;
    logic [9:0]  conv_res = 10'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        capture;
    logic        conv_start;
    logic [2:0]  conv_ch;
    logic        conv_clk_en;
    logic        conv_abort;
    logic [31:0] rd;
    logic        serr;
    logic [2:0]  vq[$];
    int          err_total = 0;
    int          checks = 0;
    int          cap_n = 0;
    int          abort_n = 0;
    int          gap = 0;
    int          last_gap = 0;
    int          core_cnt = 0;

    acsc_top acsc_top_i (.i_clock(clk), .i_reset_n(rst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_analog_pins(pins),
        .i_external_start_input(ext), .i_power_save(psave),
        .i_int_enable(int_en), .o_irq(irq), .o_capture(capture),
        .o_conv_start(conv_start), .o_conv_channel(conv_ch),
        .o_conv_clk_en(conv_clk_en), .o_conv_abort(conv_abort),
        .i_conv_done(conv_done), .i_conv_result(conv_res));

    always #50 clk = ~clk;

    // Analog core stand-in; result encodes the channel so mixups show
    always @(posedge clk) begin
        if (conv_start) begin
            vq.push_back(conv_ch);
            core_cnt <= 12;
        end else if (conv_abort)
            core_cnt <= 0;
        else if (core_cnt > 0)
            core_cnt <= core_cnt - 1;
        conv_done <= core_cnt == 1 && !conv_abort;
        conv_res <= {conv_ch[1:0], 1'b1, conv_ch, 4'h5};
        cap_n <= cap_n + int'(capture);
        abort_n <= abort_n + int'(conv_abort);
        gap <= conv_clk_en ? 1 : gap + 1;
        if (conv_clk_en)
            last_gap <= gap;
    end

    task automatic finish_test();
        $display("mismatches %0d of %0d checks", err_total, checks);
        if (err_total == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic timeout();
        err_total++;
        finish_test();
    endtask

    // One APB transfer; read data lands in rd
    task automatic apb(input logic w, input logic [7:0] ix,
                       input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, ix, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            timeout();
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Software keeps the reserved bit clear
    // reserved written zero
    task automatic ctrl(input logic [7:0] v);
        apb(1'b1, CTRL, v & 8'hdf);
    endtask

    task automatic wait_ctrl(input int b, input logic v);
        int n;
        n = 0;
        do begin
            apb(1'b0, CTRL, 8'h00);
            n++;
        end while (rd[b] !== v && n < 100);
        if (rd[b] !== v)
            timeout();
    endtask

    task automatic wait_q(input int k);
        int n;
        for (n = 0; n < 300 && vq.size() < k; n++)
            @(posedge clk);
        if (vq.size() < k)
            timeout();
    endtask

    task automatic t_reset();
        apb(1'b0, CTRL, 8'h00);
        chk(rd, 32'h0);
        apb(1'b0, SCAN, 8'h00);
        chk(rd, 32'h0);
        apb(1'b0, acsc_pkg::IDX_PIN_PORT, 8'h00);
        chk(rd, {24'h0, pins});
        apb(1'b0, 8'h10, 8'h00);
        chk({31'h0, serr}, 32'h1);
    endtask

    task automatic t_one_time();
        logic [2:0] lc [4] = '{3'h0, 3'h2, 3'h5, 3'h7};
        for (int c = 0; c < 4; c++) begin
            vq.delete();
            apb(1'b1, SCAN, 8'ha5);
            ctrl({c[1:0], 6'h08});
            ctrl({c[1:0], 6'h08});
            wait_ctrl(3, 1'b0);
            chk(32'(vq.size()), 32'h4);
            chk(32'({vq[0], vq[1], vq[2], vq[3]}), 32'h0af);
            chk(32'(rd[4]), 32'h1);
            chk(32'(last_gap), 32'(2 * (c + 1)));
            chk(32'(irq), 32'h1);
            apb(1'b0, {1'b1, lc[c], acsc_pkg::LOW_IDX_NIBBLE}, 8'h00);
            chk(rd, {24'h0, 1'b1, lc[c], 4'h5});
            apb(1'b0, acsc_pkg::IDX_HIGH_BITS, 8'h00);
            chk(rd, {30'h0, lc[c][1:0]});
            ctrl({c[1:0], 6'h10});
            apb(1'b0, CTRL, 8'h00);
            chk(32'(rd[4]), 32'h1);
            int_en <= 1'b0;
            @(posedge clk);
            @(posedge clk);
            chk(32'(irq), 32'h0);
            int_en <= 1'b1;
            ctrl({c[1:0], 6'h00});
            apb(1'b0, CTRL, 8'h00);
            chk(rd, {24'h0, c[1:0], 6'h00});
        end
    endtask

    task automatic t_empty();
        vq.delete();
        apb(1'b1, SCAN, 8'h00);
        ctrl(8'h18);
        repeat (30) @(posedge clk);
        chk(32'(vq.size()), 32'h0);
        apb(1'b0, CTRL, 8'h00);
        chk(32'(rd[3]), 32'h0);
        chk(32'(rd[4]), 32'h0);
    endtask

    task automatic t_cont();
        int n;
        vq.delete();
        apb(1'b1, SCAN, 8'h03);
        ctrl(8'h0c);
        wait_q(1);
        apb(1'b1, SCAN, 8'h80);
        wait_ctrl(4, 1'b1);
        chk(32'(rd[3]), 32'h1);
        wait_q(3);
        chk(32'({vq[0], vq[1], vq[2]}), 32'h00f);
        n = abort_n;
        ctrl(8'h04);
        repeat (3) @(posedge clk);
        chk(32'(abort_n), 32'(n + 1));
        apb(1'b0, CTRL, 8'h00);
        chk(32'(rd[3]), 32'h0);
    endtask

    // Rows: fall only, rise only; pin toggles rise, fall, rise, fall
    task automatic t_edges();
        int c;
        int q;
        apb(1'b1, SCAN, 8'h01);
        for (int i = 0; i < 4; i++) begin
            if (i == 0 || i == 2)
                ctrl(i == 0 ? 8'h01 : 8'h02);
            c = cap_n;
            q = vq.size();
            ext <= ~ext;
            repeat (6) @(posedge clk);
            chk(32'(cap_n - c), 32'(i == 1 || i == 2));
            chk(32'(vq.size() - q), 32'(i == 1 || i == 2));
            wait_ctrl(3, 1'b0);
        end
    endtask

    task automatic t_psave();
        int n;
        apb(1'b1, SCAN, 8'h01);
        ctrl(8'h0c);
        wait_ctrl(4, 1'b1);
        n = abort_n;
        psave <= 1'b1;
        repeat (4) @(posedge clk);
        psave <= 1'b0;
        chk(32'(abort_n), 32'(n + 1));
        apb(1'b0, CTRL, 8'h00);
        chk(rd & 32'h18, 32'h10);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_one_time();
        t_empty();
        t_cont();
        t_edges();
        t_psave();
        finish_test();
    end
endmodule
